// >>> hw/access_controller.sv
`timescale 1ns/1ps
module access_controller
   import pwp_pkg::*;
#(
   parameter int INSTANCE = 0
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_power_manager_clk_en,
   input wire logic i_sel,
   input wire apb_req_type i_req,
   output apb_rsp_type o_rsp,
   output logic [NUM_PERIPH-1:0] o_protect,
   output logic o_clk_en
);

   localparam logic [31:0] PROT_INIT = (INSTANCE == 0) ? PROTECT_RESET_0 :
      (INSTANCE == 1) ? PROTECT_RESET_1 : PROTECT_RESET_2;
   localparam logic CLK_INIT = CLK_EN_RESET[INSTANCE];

   logic [NUM_PERIPH-1:0] protect_r;
   logic [NUM_PERIPH-1:0] protect_nxt;
   logic clk_en_r;

   wire logic [31:0] lane_mask;
   wire logic [31:0] wmask;
   wire logic [9:0] ofs;
   wire logic is_clear;
   wire logic is_set;
   wire logic wr;
   wire logic dup_set;
   wire logic dup_clear;
   wire logic bad;

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_lane
         assign lane_mask[g*8 +: 8] = {8{i_req.strb[g]}}; // [RULE13]
      end
   endgenerate

   assign ofs = i_req.addr[9:0] & OFS_MASK;
   assign is_clear = (ofs == OFS_PROTECT_CLEAR[9:0]);
   assign is_set = (ofs == OFS_PROTECT_SET[9:0]);
   assign wr = i_sel & i_req.enable & i_req.write;
   // only ones move a bit; zeros leave it alone
   assign wmask = i_req.wdata & lane_mask; // [RULE16]
   assign dup_set = is_set & |(wmask & protect_r); // [RULE6]
   assign dup_clear = is_clear & |(wmask & ~protect_r); // [RULE7]
   // access refused while the controller clock is off or unmapped
   assign bad = ~clk_en_r | ~(is_clear | is_set) |
      (i_req.write & (dup_set | dup_clear));

   always_comb begin
      protect_nxt = protect_r;
      if (wr && !bad && is_set) begin
         protect_nxt = protect_r | wmask; // [RULE3]
      end
      if (wr && !bad && is_clear) begin
         protect_nxt = protect_r & ~wmask; // [RULE2]
      end
   end

   // single zero-wait slave; error leaves state unchanged
   assign o_rsp.ready = 1'b1;
   assign o_rsp.slverr = i_sel & bad; // [RULE17]
   // both offsets read the same state vector
   assign o_rsp.rdata = protect_r; // [RULE4]
   assign o_protect = protect_r;
   assign o_clk_en = clk_en_r;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         protect_r <= PROT_INIT;
         clk_en_r <= CLK_INIT; // [RULE10]
      end else begin
         protect_r <= protect_nxt; // [RULE9]
         clk_en_r <= i_power_manager_clk_en; // [RULE10]
      end
   end

endmodule

// >>> hw/periph_bridge.sv
//////////////////////////////////////////////////////////////////////////////
// What this block does
// RULE1: one controller per bridge, one protect bit per attached peripheral
// RULE2: one written to clear register clears that peripheral's protection
// RULE3: one written to set register sets that peripheral's protection
// RULE4: both protect registers read back the same state vector
// RULE5: protected peripheral write by non-debugger is dropped with error
// RULE6: setting an already protected peripheral returns an error
// RULE7: clearing an already unprotected peripheral returns an error
// RULE8: debugger accesses ignore protection entirely
// RULE9: protection keeps working whenever its clock is running
// RULE10: controller clock enabled after reset on instances 0,1, not 2
// RULE11: software reads set register before unprotecting from interrupts
// RULE12: bridge is a fast-bus slave issuing peripheral bus transfers
// RULE13: byte, half and word strobes on writes and reads
// RULE14: address and data phase merged into one peripheral cycle
// RULE15: bridge clock must be enabled before masters use it
// RULE16: zeros written to protect registers change nothing
// RULE17: redundant protect/unprotect leaves state and answers error
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module periph_bridge
   import pwp_pkg::*;
#(
   parameter int INSTANCE = 0
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [3:0] i_hprot,
   input wire logic [3:0] i_hmaster,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic o_hready,
   output logic o_hresp,
   output logic [31:0] o_hrdata,
   output logic [NUM_PERIPH-1:0] o_psel,
   output apb_req_type o_apb_req,
   input wire apb_rsp_type i_apb_rsp,
   input wire logic i_bridge_clk_en,
   input wire logic i_power_manager_clk_en,
   output logic o_ctrl_clk_en,
   output logic [NUM_PERIPH-1:0] o_protect
);

   //////////////////////////////////////////////////////////////////////////
   // state

   state_type state_r;
   state_type state_nxt;
   logic hready_r;
   logic hready_nxt;
   logic hresp_r;
   logic hresp_nxt;
   logic [31:0] hrdata_r;
   logic [31:0] hrdata_nxt;
   apb_req_type apb_req_r;
   apb_req_type apb_req_nxt;
   logic [NUM_PERIPH-1:0] psel_r;
   logic [NUM_PERIPH-1:0] psel_nxt;

   // address phase capture
   logic [31:0] addr_r;
   logic write_r;
   logic [3:0] strb_r;
   logic [2:0] prot_r;
   logic debug_r;

   //////////////////////////////////////////////////////////////////////////
   // decode

   wire logic idle_like;
   wire logic take;
   wire logic [3:0] strb_a;
   wire logic [2:0] prot_a;
   wire logic [SLOT_W-1:0] slot;
   wire logic ctrl_hit;
   wire logic blocked;
   wire logic [NUM_PERIPH-1:0] slot_onehot;
   wire logic ctrl_sel;
   wire apb_rsp_type ctrl_rsp;
   wire apb_rsp_type rsp;
   wire logic [NUM_PERIPH-1:0] protect;

   assign idle_like = (state_r == ST_IDLE) | (state_r == ST_ERR2);
   // valid transfer taken at the end of its address phase
   assign take = idle_like & i_hsel & i_htrans[1] & i_hready; // [RULE12]

   // byte lanes for the access, used by reads as well
   assign strb_a = (i_hsize == HSIZE_BYTE) ?
                   (4'h1 << i_haddr[1:0]) :
                   (i_hsize == HSIZE_HALF) ?
                   (i_haddr[1] ? 4'hc : 4'h3) : 4'hf; // [RULE13]
   // privileged, secure, data/instruction
   assign prot_a = {~i_hprot[0], 1'b0, i_hprot[1]}; // [RULE12]

   assign slot = addr_r[SLOT_LO +: SLOT_W];
   assign ctrl_hit = (slot == CTRL_SLOT);
   // the controller's own slot stays reachable so it can be unprotected
   assign blocked = write_r & ~debug_r & ~ctrl_hit &
                    protect[slot]; // [RULE5] [RULE8]

   genvar g;
   generate
      for (g = 0; g < NUM_PERIPH; g++) begin : g_sel
         assign slot_onehot[g] = (slot == SLOT_W'(g)) & ~ctrl_hit;
      end
   endgenerate

   assign ctrl_sel = apb_req_r.sel & ctrl_hit;
   assign rsp = ctrl_hit ? ctrl_rsp : i_apb_rsp;

   //////////////////////////////////////////////////////////////////////////
   // access controller for the peripherals of this bridge

   access_controller #(
      .INSTANCE(INSTANCE)
   ) u_ctrl ( // [RULE1]
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_power_manager_clk_en(i_power_manager_clk_en),
      .i_sel(ctrl_sel),
      .i_req(apb_req_r),
      .o_rsp(ctrl_rsp),
      .o_protect(protect),
      .o_clk_en(o_ctrl_clk_en)
   );

   //////////////////////////////////////////////////////////////////////////
   // transfer sequencing

   always_comb begin
      state_nxt = state_r;
      hready_nxt = hready_r;
      hresp_nxt = hresp_r;
      hrdata_nxt = hrdata_r;
      apb_req_nxt = apb_req_r;
      psel_nxt = psel_r;
      unique case (state_r)
         ST_IDLE, ST_ERR2: begin
            state_nxt = ST_IDLE;
            hready_nxt = 1'b1;
            hresp_nxt = HRESP_OKAY;
            if (take) begin
               hready_nxt = 1'b0;
               if (i_bridge_clk_en) begin
                  state_nxt = ST_DATA;
               end else begin
                  // bridge clock off: refuse the transfer
                  hresp_nxt = HRESP_ERROR; // [RULE15]
                  state_nxt = ST_ERR1;
               end
            end
         end
         ST_DATA: begin
            if (blocked) begin
               // write data never reaches the peripheral
               hresp_nxt = HRESP_ERROR; // [RULE5]
               state_nxt = ST_ERR1;
            end else begin
               // select and enable rise together, no setup cycle
               apb_req_nxt.sel = 1'b1; // [RULE14]
               apb_req_nxt.enable = 1'b1; // [RULE14]
               apb_req_nxt.write = write_r;
               apb_req_nxt.addr = addr_r;
               apb_req_nxt.wdata = write_r ? i_hwdata : 32'h0000_0000;
               apb_req_nxt.strb = strb_r; // [RULE13]
               apb_req_nxt.prot = prot_r;
               psel_nxt = slot_onehot;
               state_nxt = ST_ACCESS;
            end
         end
         ST_ACCESS: begin
            // wait states: hold until the peripheral is ready
            if (rsp.ready) begin // [RULE12]
               apb_req_nxt.sel = 1'b0;
               apb_req_nxt.enable = 1'b0;
               psel_nxt = '0;
               if (rsp.slverr) begin
                  hresp_nxt = HRESP_ERROR; // [RULE17]
                  state_nxt = ST_ERR1;
               end else begin
                  hready_nxt = 1'b1;
                  hrdata_nxt = write_r ? hrdata_r : rsp.rdata;
                  state_nxt = ST_IDLE;
               end
            end
         end
         ST_ERR1: begin
            // second cycle of the two-cycle error answer
            hready_nxt = 1'b1;
            state_nxt = ST_ERR2;
         end
      endcase
   end

   //////////////////////////////////////////////////////////////////////////
   // sequencer, response and request registers

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         hready_r <= 1'b1;
      end else begin
         hready_r <= hready_nxt;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         hresp_r <= HRESP_OKAY;
      end else begin
         hresp_r <= hresp_nxt;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         hrdata_r <= 32'h0000_0000;
      end else begin
         hrdata_r <= hrdata_nxt;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         apb_req_r <= '0;
      end else begin
         apb_req_r <= apb_req_nxt;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         psel_r <= '0;
      end else begin
         psel_r <= psel_nxt;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // address phase capture, loaded only when a transfer is taken

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         addr_r <= 32'h0000_0000;
      end else if (take) begin
         addr_r <= i_haddr;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         write_r <= 1'b0;
      end else if (take) begin
         write_r <= i_hwrite;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         strb_r <= 4'h0;
      end else if (take) begin
         strb_r <= strb_a;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         prot_r <= 3'h0;
      end else if (take) begin
         prot_r <= prot_a;
      end
   end

   // debugger is recognised by its master id in the address phase
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         debug_r <= 1'b0;
      end else if (take) begin
         debug_r <= (i_hmaster == DEBUG_MASTER_ID); // [RULE8]
      end
   end

   assign o_hready = hready_r;
   assign o_hresp = hresp_r;
   assign o_hrdata = hrdata_r;
   assign o_psel = psel_r;
   assign o_apb_req = apb_req_r;
   assign o_protect = protect;

endmodule

// >>> hw/pwp_pkg.sv
package pwp_pkg;

   localparam int DATA_W = 32;
   localparam int NUM_PERIPH = 32;
   // peripheral slot is taken from address bits [14:10]
   localparam int SLOT_LO = 10;
   localparam int SLOT_W = 5;
   localparam logic [4:0] CTRL_SLOT = 5'h0;

   localparam logic [11:0] OFS_PROTECT_CLEAR = 12'h000;
   localparam logic [11:0] OFS_PROTECT_SET = 12'h004;
   localparam logic [9:0] OFS_MASK = 10'h3ff;

   localparam logic [31:0] PROTECT_RESET_0 = 32'h0000_0000;
   localparam logic [31:0] PROTECT_RESET_1 = 32'h0000_0002;
   localparam logic [31:0] PROTECT_RESET_2 = 32'h0080_0000;
   // controller bus clock enable after reset, one bit per instance
   localparam logic [2:0] CLK_EN_RESET = 3'h3;

   localparam logic [3:0] DEBUG_MASTER_ID = 4'h1;

   localparam logic HRESP_OKAY = 1'b0;
   localparam logic HRESP_ERROR = 1'b1;

   localparam logic [2:0] HSIZE_BYTE = 3'h0;
   localparam logic [2:0] HSIZE_HALF = 3'h1;

   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_DATA = 5'b00010,
      ST_ACCESS = 5'b00100,
      ST_ERR1 = 5'b01000,
      ST_ERR2 = 5'b10000
   } state_type;

   typedef struct packed {
      logic sel;
      logic enable;
      logic write;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [3:0] strb;
      logic [2:0] prot;
   } apb_req_type;

   typedef struct packed {
      logic [31:0] rdata;
      logic ready;
      logic slverr;
   } apb_rsp_type;

endpackage

// >>> verification/apb_periph_model.sv
`timescale 1ns/1ps
module apb_periph_model
   import pwp_pkg::*;
(
   input wire logic i_clk_sys,
   input wire apb_req_type i_req,
   input wire logic [1:0] i_wait,
   output apb_rsp_type o_rsp
);
   logic [31:0] mem [NUM_PERIPH];
   logic [1:0] cnt_r;
   logic [31:0] junk_r;
   wire logic [4:0] sl = i_req.addr[SLOT_LO +: SLOT_W];
   wire logic rdy = i_req.sel && i_req.enable && cnt_r == i_wait;
   // idle read data toggles so stale values never look valid
   // last slot answers every access with an error
   assign o_rsp = {rdy ? mem[sl] : junk_r, rdy, rdy && sl == 5'h1f};
   initial begin
      junk_r = 32'h5a5a_a5a5;
      for (int i = 0; i < NUM_PERIPH; i++)
         mem[i] = '0;
   end
   always @(posedge i_clk_sys) begin
      junk_r <= ~junk_r;
      cnt_r <= (rdy || !i_req.sel) ? 2'h0 : cnt_r + 2'h1;
      for (int b = 0; b < 4; b++)
         if (rdy && i_req.write && i_req.strb[b])
            mem[sl][8*b +: 8] <= i_req.wdata[8*b +: 8];
   end
endmodule

// >>> verification/pwp_assertions.sv
`timescale 1ns/1ps
module pwp_checker
   import pwp_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [3:0] i_hmaster,
   input wire logic [3:0] i_hprot,
   input wire logic i_hready,
   input wire logic o_hready,
   input wire logic o_hresp,
   input wire logic [NUM_PERIPH-1:0] o_psel,
   input wire apb_req_type o_apb_req,
   input wire logic i_bridge_clk_en,
   input wire logic i_power_manager_clk_en,
   input wire logic o_ctrl_clk_en,
   input wire logic [NUM_PERIPH-1:0] o_protect
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   wire logic tk = i_hsel && i_htrans[1] && i_hready && o_hready;
   wire logic [4:0] sl = i_haddr[SLOT_LO +: SLOT_W];
   wire logic dbg = i_hmaster == DEBUG_MASTER_ID;
   wire logic ext_wr = tk && i_hwrite && i_bridge_clk_en && sl != CTRL_SLOT;
   wire logic set_rd = tk && !i_hwrite && sl == CTRL_SLOT
      && i_haddr[9:0] == OFS_PROTECT_SET[9:0];
   wire logic [4:0] req_sl = o_apb_req.addr[SLOT_LO +: SLOT_W];
   wire logic [31:0] sel_exp = (req_sl == CTRL_SLOT) ? 32'h0000_0000 :
      32'h0000_0001 << req_sl;
   //////////////////////////////////////////////////////////////////////////
   a_protect_blocks: assert property (
      ext_wr && !dbg && o_protect[sl] |=> (o_psel == '0 && !o_hready)
      ##1 (o_hresp && !o_hready && o_psel == '0) ##1 (o_hresp && o_hready))
      else $error("protected write not refused");
   a_debug_bypass: assert property (
      ext_wr && dbg |-> ##2 (o_apb_req.sel && o_apb_req.write))
      else $error("debugger write not issued");
   a_merged_phase: assert property (
      o_apb_req.sel |-> o_apb_req.enable)
      else $error("select without enable");
   a_error_pair: assert property (
      $rose(o_hresp) |-> !o_hready ##1 (o_hresp && o_hready))
      else $error("error response malformed");
   a_state_quiet: assert property (
      !$stable(o_protect) |-> !$past(o_hready))
      else $error("protect state changed while idle");
   a_clk_follow: assert property (
      !$past(i_rst) |-> o_ctrl_clk_en == $past(i_power_manager_clk_en))
      else $error("controller clock enable wrong");
   a_bridge_off: assert property (
      tk && !i_bridge_clk_en |=> (o_hresp && !o_hready)
      ##1 (o_hresp && o_hready))
      else $error("bridge off not refused");
   a_ctrl_read_okay: assert property (
      set_rd && i_bridge_clk_en && o_ctrl_clk_en
      |=> !o_hready [*2] ##1 (o_hready && !o_hresp))
      else $error("controller read latency wrong");
   a_psel_slot: assert property (
      o_psel == (o_apb_req.sel ? sel_exp : 32'h0000_0000))
      else $error("peripheral select does not match slot");
   a_prot_carry: assert property (
      $rose(o_apb_req.sel) |-> o_apb_req.prot ==
      {~$past(i_hprot[0], 2), 1'b0, $past(i_hprot[1], 2)})
      else $error("protection attributes not carried");
   c_debug_write: cover property (ext_wr && dbg);
   c_error: cover property ($rose(o_hresp));
   c_state_change: cover property (!$stable(o_protect));
endmodule
bind periph_bridge pwp_checker u_chk (.i_clk_sys, .i_rst, .i_hsel, .i_haddr,
   .i_htrans, .i_hwrite, .i_hmaster, .i_hready, .o_hready, .o_hresp, .o_psel,
   .o_apb_req, .i_bridge_clk_en, .i_power_manager_clk_en, .o_ctrl_clk_en,
   .o_protect, .i_hprot);

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top
   import pwp_pkg::*;
;
   localparam logic [31:0] P1 = PROTECT_RESET_1;
   logic i_clk_sys = 1'b0;
   logic i_rst = 1'b1;
   logic i_hsel = 1'b0;
   logic [31:0] i_haddr = '0;
   logic [1:0] i_htrans = '0;
   logic i_hwrite = 1'b0;
   logic [2:0] i_hsize = 3'h2;
   logic [3:0] i_hmaster = '0;
   logic [3:0] i_hprot = 4'h3;
   logic [31:0] i_hwdata = '0;
   logic i_bridge_clk_en = 1'b1;
   logic i_power_manager_clk_en = 1'b1;
   logic [1:0] wt = '0;
   wire logic o_hready;
   wire logic o_hresp;
   wire logic o_ctrl_clk_en;
   wire logic [31:0] o_hrdata;
   wire logic [31:0] o_psel;
   wire logic [31:0] o_protect;
   apb_req_type o_apb_req;
   apb_rsp_type i_apb_rsp;
   int error_cnt = 0;
   int checks = 0;
   periph_bridge #(.INSTANCE(1)) dut (.i_clk_sys, .i_rst, .i_hsel, .i_haddr,
      .i_htrans, .i_hwrite, .i_hsize, .i_hprot, .i_hmaster, .i_hwdata,
      .i_hready(o_hready), .o_hready, .o_hresp, .o_hrdata, .o_psel,
      .o_apb_req, .i_apb_rsp, .i_bridge_clk_en, .i_power_manager_clk_en,
      .o_ctrl_clk_en, .o_protect);
   apb_periph_model u_periph (.i_clk_sys, .i_req(o_apb_req), .i_wait(wt),
      .o_rsp(i_apb_rsp));
   initial forever #20 i_clk_sys = ~i_clk_sys;
   //////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      if (error_cnt == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic op(input logic w, input logic [31:0] a, d,
         input logic [2:0] sz, input logic [3:0] m, input logic e);
      int n;
      i_hsel = 1'b1;
      i_htrans = 2'h2;
      i_hwrite = w;
      i_haddr = a;
      i_hsize = sz;
      i_hmaster = m;
      @(posedge i_clk_sys);
      #1;
      i_htrans = 2'h0;
      i_hwdata = d;
      for (n = 0; n < 20 && o_hready !== 1'b1; n++) begin
         @(posedge i_clk_sys);
         #1;
      end
      if (n == 20) begin
         error_cnt++;
         conclude();
      end
      chk(o_hresp, e);
      if (!w && !e)
         chk(o_hrdata, d);
   endtask
   task automatic wr(input logic [31:0] a, d, input logic [3:0] m,
         input logic e);
      op(1'b1, a, d, 3'h2, m, e);
   endtask
   task automatic rd(input logic [31:0] a, d);
      op(1'b0, a, d, 3'h2, 4'h0, 1'b0);
   endtask
   task automatic t_controller();
      chk(o_protect, P1);
      chk(o_ctrl_clk_en, 32'(CLK_EN_RESET[1]));
      rd(32'h0000_0000, P1);
      rd(32'h0000_0004, P1);
      op(1'b0, 32'h0000_0008, 32'h0000_0000, 3'h2, 4'h0, 1'b1);
      wr(32'h0000_0004, 32'h0000_0010, 4'h0, 1'b0);
      chk(o_protect, 32'h0000_0012);
      wr(32'h0000_0004, 32'h0000_0010, 4'h0, 1'b1);
      rd(32'h0000_0000, 32'h0000_0012);
      rd(32'h0000_0004, 32'h0000_0012);
      wr(32'h0000_0000, 32'h0000_0010, 4'h0, 1'b0);
      wr(32'h0000_0000, 32'h0000_0010, 4'h0, 1'b1);
      chk(o_protect, P1);
   endtask
   task automatic t_protect();
      wr(32'h0000_0400, 32'hdead_beef, 4'h0, 1'b1);
      rd(32'h0000_0400, 32'h0000_0000);
      wr(32'h0000_0400, 32'h1234_5678, DEBUG_MASTER_ID, 1'b0);
      rd(32'h0000_0400, 32'h1234_5678);
      wr(32'h0000_7c00, 32'h0000_0001, 4'h0, 1'b1);
   endtask
   task automatic t_sparse();
      i_hprot = 4'h0;
      wr(32'h0000_1000, 32'h1111_1111, 4'h0, 1'b0);
      op(1'b1, 32'h0000_1002, 32'h00ab_0000, 3'h0, 4'h0, 1'b0);
      op(1'b1, 32'h0000_1000, 32'h0000_cdef, 3'h1, 4'h0, 1'b0);
      wt = 2'h2;
      rd(32'h0000_1000, 32'h11ab_cdef);
      wt = 2'h0;
      i_hprot = 4'h3;
   endtask
   task automatic t_clocks();
      i_bridge_clk_en = 1'b0;
      wr(32'h0000_1000, 32'h0000_0000, 4'h0, 1'b1);
      i_bridge_clk_en = 1'b1;
      rd(32'h0000_1000, 32'h11ab_cdef);
      i_power_manager_clk_en = 1'b0;
      repeat (2) @(posedge i_clk_sys);
      #1;
      chk(o_ctrl_clk_en, 32'h0000_0000);
      wr(32'h0000_0004, 32'h0000_0020, 4'h0, 1'b1);
      i_power_manager_clk_en = 1'b1;
      repeat (2) @(posedge i_clk_sys);
      #1;
      wr(32'h0000_0004, 32'h0000_0020, 4'h0, 1'b0);
      chk(o_protect, 32'h0000_0022);
   endtask
   initial begin
      repeat (2) @(posedge i_clk_sys);
      #1;
      i_rst = 1'b0;
      t_controller();
      t_protect();
      t_sparse();
      t_clocks();
      conclude();
   end
endmodule
